// ===== include/card_port_pkg.sv
// Shared constants and types for the card register port and its host end
package card_port_pkg;
  // Configuration modes of the card
  typedef enum logic [1:0] {
    MODE_MEMORY,
    MODE_CONTIG,
    MODE_PRIMARY,
    MODE_SECONDARY
  } map_mode_type;
  // Task register offsets inside the block
  localparam logic [3:0] OFS_DATA = 4'h0;
  localparam logic [3:0] OFS_FAULT = 4'h1;
  localparam logic [3:0] OFS_DRIVE_HEAD = 4'h6;
  localparam logic [3:0] OFS_COMMAND = 4'h7;
  localparam logic [3:0] OFS_DATA_COPY = 4'h8;
  localparam logic [3:0] OFS_FAULT_COPY = 4'hd;
  localparam logic [3:0] OFS_ALT_STATUS = 4'he;
  // Standard I/O bases
  localparam logic [10:0] PRI_BASE = 11'h1f0;
  localparam logic [10:0] PRI_ALT = 11'h3f6;
  localparam logic [10:0] SEC_BASE = 11'h170;
  localparam logic [10:0] SEC_ALT = 11'h376;
  localparam logic [7:0] CMD_DIAG = 8'h90;
  localparam logic [7:0] STATUS_READY = 8'h50;
  localparam logic [7:0] DIAG_PASS = 8'h01;
  localparam int DRIVE_BIT = 4;
  localparam int IDX_BIT = 1;
  // Busy time after reset
  localparam int BUSY_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int BUSY_CYCLES = BUSY_TIME_NS / CLK_PERIOD_NS;
  localparam int IDX_PERIOD = 64;
  // Host APB register map
  localparam logic [7:0] APB_CTRL = 8'h00;
  localparam logic [7:0] APB_DATA = 8'h04;
  localparam logic [7:0] APB_STATUS = 8'h08;
  localparam logic [7:0] APB_IRQ_STAT = 8'h0c;
  localparam logic [7:0] APB_IRQ_CLR = 8'h10;
  localparam logic [7:0] APB_IRQ_EN = 8'h14;
  localparam int CTRL_GO = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_WORD = 2;
  localparam int CTRL_ADDR_LSB = 8;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_READY = 1;
  localparam int STROBE_CYCLES = 4;
endpackage

// ===== include/card_bus_if.sv
// Card slot signals between host socket and card
`timescale 1ns/1ns
`default_nettype none
interface card_bus_if;
  logic [10:0] addr;
  logic ce1_n;
  logic ce2_n;
  logic iord_n;
  logic iowr_n;
  logic [15:0] host_d;
  logic host_d_oe;
  logic [15:0] card_d;
  logic card_d_oe;
  logic iois16_n;
  logic ready_busy;
  logic socket_copy;
  modport host (
    output addr, ce1_n, ce2_n, iord_n, iowr_n, host_d, host_d_oe, socket_copy,
    input card_d, card_d_oe, iois16_n, ready_busy
  );
  modport card (
    input addr, ce1_n, ce2_n, iord_n, iowr_n, host_d, host_d_oe, socket_copy,
    output card_d, card_d_oe, iois16_n, ready_busy
  );
endinterface
`default_nettype wire

// ===== logic/ata_card_device.sv
// Card end: decode, byte lanes, task registers and busy line
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ata_card_device
  import card_port_pkg::*;
#(
  parameter int BUSY_LEN = BUSY_CYCLES,
  parameter bit HAS_IDX = 1'b1
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  card_bus_if.card bus,
  input wire map_mode_type i_mode,
  input wire logic i_soft_reset,
  output logic o_irq_mem,
  output logic o_busy
);
  // Busy counter is 16 bits wide
  if (BUSY_LEN < 1 || BUSY_LEN > 65536) begin : g_busy_len_check
    $error("BUSY_LEN must be between 1 and 65536");
  end
  // Pin synchronisers
  logic [1:0] ce1_s, ce2_s, rd_s, wr_s;
  logic [10:0] addr_s1, addr_s2;
  logic [15:0] d_s1, d_s2;
  logic copy_s1, copy_s2;
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ce1_s <= 2'h3;
      ce2_s <= 2'h3;
      rd_s <= 2'h3;
      wr_s <= 2'h3;
      addr_s1 <= 11'h000;
      addr_s2 <= 11'h000;
      d_s1 <= 16'h0000;
      d_s2 <= 16'h0000;
      copy_s1 <= 1'b0;
      copy_s2 <= 1'b0;
    end else begin
      ce1_s <= {ce1_s[0], bus.ce1_n};
      ce2_s <= {ce2_s[0], bus.ce2_n};
      rd_s <= {rd_s[0], bus.iord_n};
      wr_s <= {wr_s[0], bus.iowr_n};
      addr_s1 <= bus.addr;
      addr_s2 <= addr_s1;
      d_s1 <= bus.host_d;
      d_s2 <= d_s1;
      copy_s1 <= bus.socket_copy;
      copy_s2 <= copy_s1;
    end
  end
  // Active-high enables from low-asserted pins
  logic ce1, ce2, any_ce, rd, wr;
  assign ce1 = !ce1_s[1];
  assign ce2 = !ce2_s[1];
  assign any_ce = ce1 || ce2;
  assign rd = any_ce && !rd_s[1];
  assign wr = any_ce && !wr_s[1];
  // Address decode per mode, returns hit and block offset
  function automatic logic [4:0] decode(input logic [10:0] a, input map_mode_type m);
    logic [10:0] base, alt;
    decode = 5'h00;
    base = (m == MODE_PRIMARY) ? PRI_BASE : SEC_BASE;
    alt = (m == MODE_PRIMARY) ? PRI_ALT : SEC_ALT;
    if (m == MODE_MEMORY || m == MODE_CONTIG) begin
      decode = {1'b1, a[3:0]};
    end else if (a[10:3] == base[10:3]) begin
      decode = {1'b1, 1'b0, a[2:0]};
    end else if (a[10:1] == alt[10:1]) begin
      decode = {1'b1, 3'h7, a[0]};
    end
  endfunction
  logic [4:0] hit;
  logic [3:0] ofs, reg_ofs;
  logic wide_mode;
  assign hit = decode(addr_s2, i_mode);
  assign wide_mode = (i_mode == MODE_MEMORY) || (i_mode == MODE_CONTIG);
  assign ofs = hit[3:0];
  // Register offset of access; CE2 alone selects the odd byte
  assign reg_ofs = (ce2 && !ce1) ? (ofs | 4'h1) : ofs;
  // Task register state
  logic [15:0] data_reg;
  logic [7:0] fault_reg, feature_reg, dh_reg, status_reg;
  logic [15:0] busy_cnt_reg;
  logic busy_reg, busy_d_reg;
  logic wr_d_reg;
  logic [5:0] idx_cnt_reg;
  logic drive_pos_reg;
  logic is_data, is_fault;
  // Odd byte at offset 1 through CE1 is the fault register, not data
  assign is_data = !is_fault && ((reg_ofs[3:1] == OFS_DATA[3:1]) ||
                   (wide_mode && reg_ofs[3:1] == OFS_DATA_COPY[3:1]));
  assign is_fault = (!ce2 && reg_ofs == OFS_FAULT) ||
                    (wide_mode && reg_ofs == OFS_FAULT_COPY);
  // Drive position latched from the copy register, no strap
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) drive_pos_reg <= 1'b0;
    else if (busy_reg) drive_pos_reg <= copy_s2;
  end
  // Busy timer after power-on, hardware or soft reset
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_cnt_reg <= 16'h0000;
      busy_reg <= 1'b1;
    end else if (i_soft_reset) begin
      busy_cnt_reg <= 16'h0000;
      busy_reg <= 1'b1;
    end else if (busy_reg) begin
      busy_cnt_reg <= busy_cnt_reg + 16'h0001;
      if (busy_cnt_reg == 16'(BUSY_LEN - 1)) busy_reg <= 1'b0;
    end
  end
  // Register writes on strobe edge
  logic wr_edge, selected;
  assign wr_edge = wr && !wr_d_reg && hit[4] && !busy_reg;
  assign selected = (dh_reg[DRIVE_BIT] == drive_pos_reg);
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_d_reg <= 1'b0;
      data_reg <= 16'h0000;
      feature_reg <= 8'h00;
      dh_reg <= 8'h00;
      fault_reg <= 8'h00;
    end else begin
      wr_d_reg <= wr;
      if (wr_edge) begin
        if (is_data) begin
          if (ce1 && !reg_ofs[0]) data_reg[7:0] <= d_s2[7:0];
          if (ce2) data_reg[15:8] <= d_s2[15:8];
          else if (reg_ofs[0]) data_reg[15:8] <= d_s2[7:0];
        end else if (is_fault) begin
          feature_reg <= ce2 ? d_s2[15:8] : d_s2[7:0];
        end else if (reg_ofs == OFS_DRIVE_HEAD) begin
          dh_reg <= d_s2[7:0];
        end else if (reg_ofs == OFS_COMMAND && d_s2[7:0] == CMD_DIAG && selected) begin
          fault_reg <= DIAG_PASS;
        end
      end
    end
  end
  // Index bit pulses high one cycle in every 64 when present
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) idx_cnt_reg <= 6'h00;
    else idx_cnt_reg <= idx_cnt_reg + 6'h01;
  end
  always_comb begin
    status_reg = busy_reg ? 8'h80 : STATUS_READY;
    if (HAS_IDX) status_reg[IDX_BIT] = (idx_cnt_reg == 6'(IDX_PERIOD - 1));
  end
  // Read byte at odd or even register
  logic [7:0] even_b, odd_b;
  always_comb begin
    even_b = 8'h00;
    odd_b = 8'h00;
    if (is_data) begin
      even_b = data_reg[7:0];
      odd_b = data_reg[15:8];
    end else begin
      odd_b = is_fault ? fault_reg : 8'h00;
      if ({reg_ofs[3:1], 1'b0} == OFS_DRIVE_HEAD) even_b = dh_reg;
      if (reg_ofs == OFS_COMMAND) odd_b = status_reg;
      if (reg_ofs == OFS_ALT_STATUS) even_b = status_reg; // Even offset 0xe
      if (reg_ofs == OFS_DRIVE_HEAD) even_b = dh_reg;
    end
  end
  // Data pins from flip-flops
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bus.card_d <= 16'h0000;
      bus.card_d_oe <= 1'b0;
    end else begin
      bus.card_d_oe <= rd && hit[4];
      if (ce2) bus.card_d <= {odd_b, ce1 ? even_b : 8'h00};
      else if (reg_ofs[0]) bus.card_d <= {8'h00, odd_b};
      else bus.card_d <= {8'h00, even_b};
    end
  end
  // Word acknowledge for the data register only
  assign bus.iois16_n = !(any_ce && hit[4] && is_data);
  // Ready high, busy low
  assign bus.ready_busy = !busy_reg;
  assign o_busy = busy_reg;
  // Busy-to-ready event in memory mode
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_d_reg <= 1'b1;
      o_irq_mem <= 1'b0;
    end else begin
      busy_d_reg <= busy_reg;
      o_irq_mem <= busy_d_reg && !busy_reg && i_mode == MODE_MEMORY;
    end
  end
endmodule
`default_nettype wire

// ===== logic/ata_card_host.sv
// Host socket end: APB registers driving card cycles
`timescale 1ns/1ns
`default_nettype none
module ata_card_host
  import card_port_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_irq,
  card_bus_if.host bus
);
  typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_NEXT} host_state_type;
  host_state_type state_reg;
  logic [31:0] ctrl_reg;
  logic [15:0] wdata_reg, rdata_reg;
  logic [1:0] irq_stat_reg, irq_en_reg;
  logic [3:0] cnt_reg;
  logic second_reg, word_reg;
  logic [1:0] rdy_s, io16_s;
  logic ready_edge, done_pulse, ready_d_reg;
  // Card pin synchronisers
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdy_s <= 2'h0;
      io16_s <= 2'h3;
      ready_d_reg <= 1'b0;
    end else begin
      rdy_s <= {rdy_s[0], bus.ready_busy};
      io16_s <= {io16_s[0], bus.iois16_n};
      ready_d_reg <= rdy_s[1];
    end
  end
  assign ready_edge = rdy_s[1] && !ready_d_reg;
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;
  // APB register writes and start
  logic apb_wr, start;
  assign apb_wr = i_psel && i_penable && i_pwrite;
  assign start = apb_wr && i_paddr == APB_CTRL && i_pwdata[CTRL_GO] &&
                 state_reg == ST_IDLE && rdy_s[1];
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_reg <= 32'h0;
      wdata_reg <= 16'h0;
      irq_en_reg <= 2'h0;
    end else if (apb_wr) begin
      if (i_paddr == APB_CTRL && state_reg == ST_IDLE) ctrl_reg <= i_pwdata;
      else if (i_paddr == APB_DATA) wdata_reg <= i_pwdata[15:0];
      else if (i_paddr == APB_IRQ_EN) irq_en_reg <= i_pwdata[1:0];
    end
  end
  // Sticky events, set wins over clear
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) irq_stat_reg <= 2'h0;
    else begin
      if (apb_wr && i_paddr == APB_IRQ_CLR) irq_stat_reg <= irq_stat_reg & ~i_pwdata[1:0];
      if (done_pulse) irq_stat_reg[IRQ_DONE] <= 1'b1;
      if (ready_edge) irq_stat_reg[IRQ_READY] <= 1'b1;
    end
  end
  assign o_irq = |(irq_stat_reg & irq_en_reg);
  // Read mux
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) o_prdata <= 32'h0;
    else if (i_psel && !i_penable) begin
      if (i_paddr == APB_CTRL) o_prdata <= ctrl_reg;
      else if (i_paddr == APB_DATA) o_prdata <= {16'h0, rdata_reg};
      else if (i_paddr == APB_STATUS) o_prdata <= {29'h0, word_reg, rdy_s[1], state_reg != ST_IDLE};
      else if (i_paddr == APB_IRQ_STAT) o_prdata <= {30'h0, irq_stat_reg};
      else if (i_paddr == APB_IRQ_EN) o_prdata <= {30'h0, irq_en_reg};
      else o_prdata <= 32'h0;
    end
  end
  // Card cycle sequencer
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      second_reg <= 1'b0;
      word_reg <= 1'b0;
      done_pulse <= 1'b0;
      rdata_reg <= 16'h0;
      bus.addr <= 11'h0;
      bus.ce1_n <= 1'b1;
      bus.ce2_n <= 1'b1;
      bus.iord_n <= 1'b1;
      bus.iowr_n <= 1'b1;
      bus.host_d <= 16'h0;
      bus.host_d_oe <= 1'b0;
      bus.socket_copy <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            second_reg <= 1'b0;
            word_reg <= i_pwdata[CTRL_WORD];
            bus.addr <= {i_pwdata[CTRL_ADDR_LSB+1 +: 10], 1'b0};
            if (!i_pwdata[CTRL_WORD]) bus.addr <= i_pwdata[CTRL_ADDR_LSB +: 11];
            bus.ce1_n <= 1'b0;
            bus.ce2_n <= !i_pwdata[CTRL_WORD];
            cnt_reg <= 4'h0;
            state_reg <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          cnt_reg <= cnt_reg + 4'h1;
          // Word acknowledge needs two card and two host flops to arrive
          if (cnt_reg == 4'(STROBE_CYCLES)) begin
            cnt_reg <= 4'h0;
            if (word_reg && io16_s[1]) begin
              // No word acknowledge: drop CE2, rerun setup as even byte
              word_reg <= 1'b0;
              bus.ce2_n <= 1'b1;
            end else begin
              bus.iord_n <= ctrl_reg[CTRL_WRITE];
              bus.iowr_n <= !ctrl_reg[CTRL_WRITE];
              bus.host_d <= second_reg ? {8'h00, wdata_reg[15:8]} : wdata_reg;
              bus.host_d_oe <= ctrl_reg[CTRL_WRITE];
              state_reg <= ST_STROBE;
            end
          end
        end
        ST_STROBE: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == 4'(STROBE_CYCLES + 1)) begin
            if (!ctrl_reg[CTRL_WRITE]) begin
              if (word_reg) rdata_reg <= bus.card_d;
              else if (second_reg) rdata_reg[15:8] <= bus.card_d[7:0];
              else rdata_reg[7:0] <= bus.card_d[7:0];
            end
            bus.iord_n <= 1'b1;
            bus.iowr_n <= 1'b1;
            state_reg <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          bus.host_d_oe <= 1'b0;
          // Even byte first, then odd byte
          if (ctrl_reg[CTRL_WORD] && !word_reg && !second_reg) begin
            second_reg <= 1'b1;
            bus.addr <= bus.addr | 11'h001;
            cnt_reg <= 4'h0;
            state_reg <= ST_SETUP;
          end else begin
            bus.ce1_n <= 1'b1;
            bus.ce2_n <= 1'b1;
            done_pulse <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== testbench/card_bus_props.sv
// Concurrent checks on the card slot signals between the two ends
`timescale 1ns/1ns
`default_nettype none
module card_bus_props (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic [10:0] addr,
  input wire logic ce1_n,
  input wire logic ce2_n,
  input wire logic iord_n,
  input wire logic iowr_n,
  input wire logic card_d_oe,
  input wire logic iois16_n,
  input wire logic ready_busy
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  // Busy line and register access around resets
  a_reset_busy: assert property ($rose(i_nrst) |-> (!ready_busy)[*3])
    else $error("busy line not low after reset");
  a_no_access_busy: assert property (!ready_busy |-> iord_n && iowr_n)
    else $error("strobe while card busy");
  // Data lines released when not selected or not read
  a_idle_undriven: assert property ((ce1_n && ce2_n)[*5] |-> !card_d_oe)
    else $error("card drives data without enable");
  a_read_only_oe: assert property (iord_n[*5] |-> !card_d_oe)
    else $error("card drives data without read strobe");
  a_strobe_enable: assert property (!(iord_n && iowr_n) |-> !(ce1_n && ce2_n))
    else $error("strobe without card enable");
  // Word cycles
  a_word_even: assert property ((!ce1_n && !ce2_n) |-> !addr[0])
    else $error("word access with odd address");
  a_word_ack: assert property ((!ce1_n && !ce2_n && !(iord_n && iowr_n)) |-> !iois16_n)
    else $error("word cycle without 16-bit acknowledge");
  a_addr_steady: assert property (!(iord_n && iowr_n) |-> $stable(addr) && $stable(ce2_n))
    else $error("address or enable moved during strobe");
  // Main scenarios
  c_word_read: cover property (!ce1_n && !ce2_n && !iord_n);
  c_odd_byte: cover property (!ce1_n && ce2_n && addr[0] && !iord_n);
  c_ready: cover property ($rose(ready_busy));
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Bench joining host and card ends through the slot interface
`timescale 1ns/1ns
`default_nettype none
module testbench
  import card_port_pkg::*;
;
  logic clk, nrst, psel, penable, pwrite, soft_rst, irq, irq_mem, busy, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] lane_rd;
  logic lane_ce2;
  map_mode_type mode;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_pulse = 0;
  card_bus_if bus();
  ata_card_host ata_card_host_i (.i_sys_clk(clk), .i_nrst(nrst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq), .bus(bus));
  ata_card_device #(.BUSY_LEN(4)) ata_card_device_i (.i_sys_clk(clk), .i_nrst(nrst),
    .bus(bus), .i_mode(mode), .i_soft_reset(soft_rst), .o_irq_mem(irq_mem), .o_busy(busy));
  card_bus_props card_bus_props_i (.i_sys_clk(clk), .i_nrst(nrst), .addr(bus.addr),
    .ce1_n(bus.ce1_n), .ce2_n(bus.ce2_n), .iord_n(bus.iord_n), .iowr_n(bus.iowr_n),
    .card_d_oe(bus.card_d_oe), .iois16_n(bus.iois16_n), .ready_busy(bus.ready_busy));
  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Capture read lanes and count memory-mode ready pulses
  always @(posedge clk) begin
    if (bus.card_d_oe === 1'b1 && bus.iord_n === 1'b0) begin
      lane_rd <= bus.card_d;
      lane_ce2 <= bus.ce2_n;
    end
    if (irq_mem === 1'b1) n_pulse++;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One APB transfer, read data left in rd
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      apb(1'b0, APB_STATUS, 32'h0);
      n++;
    end while (rd[1] !== 1'b1 && n < 100);
    check(rd[1], 1'b1, "card ready");
  endtask
  // One card cycle started from the host registers
  task automatic cyc(input logic wr, input logic word, input logic [10:0] a,
    input logic [15:0] d);
    int n;
    n = 0;
    wait_ready();
    apb(1'b1, APB_IRQ_CLR, 32'h3);
    apb(1'b1, APB_DATA, {16'h0, d});
    apb(1'b1, APB_CTRL, {13'h0, a, 5'h0, word, wr, 1'b1});
    do begin
      apb(1'b0, APB_IRQ_STAT, 32'h0);
      n++;
    end while (rd[IRQ_DONE] !== 1'b1 && n < 100);
    check(rd[IRQ_DONE], 1'b1, "cycle done");
    apb(1'b0, APB_DATA, 32'h0);
  endtask
  task automatic do_reset();
    nrst <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
  endtask
  task automatic t_busy();
    check(bus.ready_busy, 1'b0, "busy after reset");
    check(busy, 1'b1, "busy flag");
    apb(1'b1, APB_CTRL, 32'h1);
    apb(1'b0, APB_STATUS, 32'h0);
    check(rd[0], 1'b0, "start while busy");
    wait_ready();
    check(bus.ready_busy, 1'b1, "ready level");
  endtask
  // Diagnostic and register reads in every mapping
  task automatic t_map();
    logic [10:0] base, alt;
    for (int m = 0; m < 4; m++) begin
      mode <= map_mode_type'(m);
      base = (m == 2) ? PRI_BASE : (m == 3) ? SEC_BASE : 11'h0;
      alt = (m == 2) ? PRI_ALT : SEC_ALT;
      cyc(1'b1, 1'b0, base + 11'(OFS_DRIVE_HEAD), 16'h0);
      cyc(1'b1, 1'b0, base + 11'(OFS_COMMAND), {8'h0, CMD_DIAG});
      cyc(1'b0, 1'b0, base + 11'(OFS_FAULT), 16'h0);
      check(rd[7:0], DIAG_PASS, "fault byte");
      check({lane_ce2, lane_rd[7:0]}, {1'b1, DIAG_PASS}, "odd byte lanes");
      cyc(1'b1, 1'b1, base + 11'(OFS_DATA), 16'h5a3c + 16'(m));
      cyc(1'b0, 1'b1, base + 11'(OFS_DATA), 16'h0);
      check(rd[15:0], 16'h5a3c + 16'(m), "data word");
      apb(1'b0, APB_STATUS, 32'h0);
      check(rd[2], 1'b1, "word acknowledged");
      if (m < 2) begin
        cyc(1'b0, 1'b0, 11'(OFS_FAULT_COPY), 16'h0);
        check(rd[7:0], DIAG_PASS, "fault copy");
        cyc(1'b0, 1'b1, 11'(OFS_DATA_COPY), 16'h0);
        check(rd[15:0], 16'h5a3c + 16'(m), "data copy");
      end else begin
        cyc(1'b0, 1'b0, alt, 16'h0);
        check(rd[7:0] & ~(8'h1 << IDX_BIT), STATUS_READY, "alternate status");
      end
    end
  endtask
  task automatic t_irq();
    mode <= MODE_CONTIG;
    apb(1'b1, APB_IRQ_EN, 32'h1);
    cyc(1'b0, 1'b0, 11'(OFS_FAULT), 16'h0);
    repeat (2) @(posedge clk);
    check(irq, 1'b1, "done raises irq");
    apb(1'b1, APB_IRQ_CLR, 32'h1);
    repeat (2) @(posedge clk);
    check(irq, 1'b0, "clear drops irq");
    apb(1'b1, APB_IRQ_EN, 32'h0);
    cyc(1'b0, 1'b0, 11'(OFS_FAULT), 16'h0);
    apb(1'b0, APB_IRQ_STAT, 32'h0);
    check({irq, rd[IRQ_DONE]}, 2'b01, "masked but sticky");
  endtask
  // Soft reset: busy again, ready event in both modes, memory ready pulse in memory mode only
  task automatic t_soft();
    int p;
    for (int m = 0; m < 2; m++) begin
      mode <= (m == 0) ? MODE_MEMORY : MODE_CONTIG;
      apb(1'b1, APB_IRQ_EN, 32'h2);
      apb(1'b1, APB_IRQ_CLR, 32'h3);
      p = n_pulse;
      soft_rst <= 1'b1;
      @(posedge clk);
      soft_rst <= 1'b0;
      repeat (2) @(posedge clk);
      check(busy, 1'b1, "soft reset busy");
      wait_ready();
      repeat (2) @(posedge clk);
      check(n_pulse - p, (m == 0) ? 1 : 0, "memory ready pulse");
      apb(1'b0, APB_IRQ_STAT, 32'h0);
      check({irq, rd[IRQ_READY]}, 2'b11, "ready event");
      apb(1'b1, APB_IRQ_CLR, 32'h3);
      apb(1'b1, APB_IRQ_EN, 32'h0);
    end
  endtask
  // Word to drive-head pair falls back to bytes; unselected diagnostic
  task automatic t_unsel();
    cyc(1'b1, 1'b1, 11'(OFS_DRIVE_HEAD), {CMD_DIAG, 8'(1 << DRIVE_BIT)});
    apb(1'b0, APB_STATUS, 32'h0);
    check(rd[2], 1'b0, "byte fallback");
    cyc(1'b0, 1'b0, 11'(OFS_FAULT), 16'h0);
    check(rd[7:0], 8'h00, "unselected diagnostic");
  endtask
  // Watchdog
  initial begin
    #160000;
    n_mismatch++;
    $display("MISMATCH %0t watchdog expired", $time);
    give_verdict();
  end
  // Main sequence
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    mode = MODE_MEMORY;
    soft_rst = 1'b0;
    do_reset();
    t_busy();
    t_map();
    t_irq();
    t_soft();
    do_reset();
    t_busy();
    t_unsel();
    give_verdict();
  end
endmodule
`default_nettype wire
